// *** flash_seq_pkg.sv ***
// Shared constants for the serial flash read and buffer-fill sequencer.
// Assumes SPI mode 0 or 3 framing by an outside host; no other users.
package flash_seq_pkg;

    // Opcodes handled by this block
    localparam logic [7:0] OP_READ_LOW_FREQ  = 8'h03;
    localparam logic [7:0] OP_READ_LOW_POWER = 8'h01;
    localparam logic [7:0] OP_PAGE_READ      = 8'hd2;
    localparam logic [7:0] OP_BUF_READ_FAST  = 8'hd4;
    localparam logic [7:0] OP_BUF_READ_SLOW  = 8'hd1;
    localparam logic [7:0] OP_BUF_WRITE      = 8'h84;

    // Header bit indices (zero based) at which each phase ends, and the last bit of a data byte
    localparam logic [6:0] OPCODE_END      = 7'h07;
    localparam logic [6:0] ADDR_END        = 7'h1f;
    localparam logic [6:0] BUF_FAST_END    = 7'h27;
    localparam logic [6:0] PAGE_READ_END   = 7'h3f;
    localparam logic [2:0] BYTE_LAST_BIT   = 3'h7;

    // Array and page geometry
    localparam int         NUM_PAGES       = 1024;
    localparam int         PAGE_BYTES_MAX  = 264;
    localparam logic [8:0] LAST_BYTE_264   = 9'h107;
    localparam logic [8:0] LAST_BYTE_256   = 9'h0ff;
    localparam logic [18:0] PAGE_STRIDE    = 19'h00108;

    // Address field positions
    localparam int PAGE_LSB_264 = 9;
    localparam int PAGE_LSB_256 = 8;
    localparam int PAGE_W       = 10;
    localparam int BYTE_W       = 9;
    localparam int IDX_W        = 19;

endpackage : flash_seq_pkg

// *** pin_sync_if.sv ***
// Synchronised pin events passed from the pin sampler to the sequencer core.
// Assumes both ends run on the same clk.
`timescale 1ns/1ps
interface pin_sync_if;
    logic cs_low;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic si_bit;
    logic page_264;

    modport front (output cs_low, cs_rise, sck_rise, sck_fall, si_bit, page_264);
    modport core  (input  cs_low, cs_rise, sck_rise, sck_fall, si_bit, page_264);
endinterface : pin_sync_if

// *** spi_pin_sync.sv ***
// Two-flop synchronisers for the serial pins and edge detection of clock and select.
// Assumes the serial clock is several times slower than clk.
`timescale 1ns/1ps
module spi_pin_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Raw pins
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic page_264,
    // Events
    pin_sync_if.front sy
);
    logic [1:0] cs_s_r;
    logic [1:0] sck_s_r;
    logic [1:0] si_s_r;
    logic [1:0] ps_s_r;
    logic       cs_d_r;
    logic       sck_d_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cs_s_r  <= 2'h3;
            sck_s_r <= 2'h0;
            si_s_r  <= 2'h0;
            ps_s_r  <= 2'h0;
        end
        else
        begin
            cs_s_r  <= {cs_s_r[0], cs_n};
            sck_s_r <= {sck_s_r[0], sck};
            si_s_r  <= {si_s_r[0], si};
            ps_s_r  <= {ps_s_r[0], page_264};
        end
    end

    // Edge history only ever looks at the second stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cs_d_r  <= 1'b1;
            sck_d_r <= 1'b0;
        end
        else
        begin
            cs_d_r  <= cs_s_r[1];
            sck_d_r <= sck_s_r[1];
        end
    end

    assign sy.cs_low   = ~cs_s_r[1];
    assign sy.cs_rise  = cs_s_r[1] & ~cs_d_r;
    assign sy.sck_rise = sck_s_r[1] & ~sck_d_r & ~cs_s_r[1];
    assign sy.sck_fall = ~sck_s_r[1] & sck_d_r & ~cs_s_r[1];
    assign sy.si_bit   = si_s_r[1];
    assign sy.page_264 = ps_s_r[1];

endmodule : spi_pin_sync

// *** data_buffer_ram.sv ***
// On-chip SRAM data buffer: one write port, one registered read port.
// Assumes callers keep addresses below DEPTH.
`timescale 1ns/1ps
module data_buffer_ram
#(
    parameter int DEPTH = 264,
    parameter int WIDTH = 8,
    parameter int AW    = 9
)
(
    // Clock
    input  wire logic             clk,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read port, one cycle latency
    input  wire logic [AW-1:0]    rd_addr,
    output      logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        rd_data <= mem[rd_addr];
    end

endmodule : data_buffer_ram

// *** flash_read_seq.sv ***
// Serial flash command sequencer for array reads, page reads and buffer access.
// Assumes a host framing commands with cs_n and SPI mode 0/3 clocking on sck.
// Contract
// [R1] Command starts at select fall, 8-bit opcode
// [R2] Everything shifted most significant bit first
// [R3] Opcode 03h: three address bytes, then data
// [R4] Opcode 01h: three address bytes, then data
// [R5] 264 mode: ten page, nine byte bits
// [R6] 256 mode: ten page, eight byte bits
// [R7] Continuous read crosses pages without gaps
// [R8] Array end wraps to page zero seamlessly
// [R9] Host holds select low whole command
// [R10] Select rise ends read, releases output
// [R11] Array reads never touch the buffer
// [R12] Any of 1024 pages selectable
// [R13] Opcode D2h: address, four dummies, then data
// [R14] Page read wraps within same page
// [R15] D4h one dummy byte, D1h none
// [R16] Buffer address: dummy bits plus offset
// [R17] Buffer read wraps to offset zero
// [R18] Opcode 84h: address gives first buffer byte
// [R19] Buffer write stores consecutive bytes, wrapping
// [R20] Buffer write runs until select rises
// [R21] Page size input sets decode and wraps
`timescale 1ns/1ps
module flash_read_seq
#(
    parameter int PAGES     = flash_seq_pkg::NUM_PAGES,
    parameter int PAGE_SIZE = flash_seq_pkg::PAGE_BYTES_MAX
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Serial pins
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        si,
    output      logic        so_o,
    output      logic        so_oe_n,
    // Configuration
    input  wire logic        page_264,
    // Array preload port
    input  wire logic        arr_ld_en,
    input  wire logic [9:0]  arr_ld_page,
    input  wire logic [8:0]  arr_ld_byte,
    input  wire logic [7:0]  arr_ld_data,
    // Status
    output      logic        busy
);
    typedef enum logic [5:0] {
        ST_OPCODE = 6'h01,
        ST_ADDR   = 6'h02,
        ST_DUMMY  = 6'h04,
        ST_READ   = 6'h08,
        ST_WRITE  = 6'h10,
        ST_SKIP   = 6'h20
    } seq_state_t;

    localparam int PW = flash_seq_pkg::PAGE_W;
    localparam int BW = flash_seq_pkg::BYTE_W;
    localparam int IW = flash_seq_pkg::IDX_W;

    pin_sync_if sy ();

    seq_state_t    state_r;
    seq_state_t    state_nxt;
    logic [6:0]    hcnt_r;
    logic [31:0]   hdr_r;
    logic [31:0]   hdr_nxt;
    logic [7:0]    op_r;
    logic [PW-1:0] page_r;
    logic [BW-1:0] byte_r;
    logic [2:0]    obit_r;
    logic [7:0]    osh_r;
    logic          so_r;
    logic          oe_n_r;
    logic [2:0]    wbit_r;
    logic [7:0]    wsh_r;
    logic [7:0]    wbyte;
    logic          buf_wr_en;
    logic [7:0]    arr_q_r;
    logic [7:0]    buf_q;
    logic [7:0]    src_byte;
    logic [BW-1:0] last_byte;
    logic          is_buf_op;
    logic          is_page_op;
    logic          at_last;
    logic          advance;
    logic [IW-1:0] arr_idx;
    logic [IW-1:0] ld_idx;
    logic [PW-1:0] page_dec;
    logic [BW-1:0] byte_dec;
    logic          op_known;
    logic [7:0]    op_in;
    logic [6:0]    hdr_end;

    logic [7:0]    array_mem [0:PAGES*PAGE_SIZE-1];

    spi_pin_sync u_sync
    (
        .clk      (clk),
        .rst      (rst),
        .cs_n     (cs_n),
        .sck      (sck),
        .si       (si),
        .page_264 (page_264),
        .sy       (sy)
    );

    data_buffer_ram
    #(
        .DEPTH (PAGE_SIZE),
        .WIDTH (8),
        .AW    (BW)
    )
    u_buf
    (
        .clk     (clk),
        .wr_en   (buf_wr_en),
        .wr_addr (byte_r),
        .wr_data (wbyte),
        .rd_addr (byte_r),
        .rd_data (buf_q)
    );

    // Header shifting and opcode/address decode
    assign hdr_nxt  = {hdr_r[30:0], sy.si_bit};                          // [R2]
    assign op_in    = hdr_nxt[7:0];
    assign op_known = (op_in == flash_seq_pkg::OP_READ_LOW_FREQ)
                   || (op_in == flash_seq_pkg::OP_READ_LOW_POWER)
                   || (op_in == flash_seq_pkg::OP_PAGE_READ)
                   || (op_in == flash_seq_pkg::OP_BUF_READ_FAST)
                   || (op_in == flash_seq_pkg::OP_BUF_READ_SLOW)
                   || (op_in == flash_seq_pkg::OP_BUF_WRITE);

    // The byte field also serves as the buffer offset; upper bits are dummies
    always_comb
    begin
        if (sy.page_264)                                                  // [R21]
        begin
            page_dec = hdr_nxt[flash_seq_pkg::PAGE_LSB_264 +: PW];       // [R5]
            byte_dec = hdr_nxt[BW-1:0];                                   // [R5] [R16]
        end
        else
        begin
            page_dec = hdr_nxt[flash_seq_pkg::PAGE_LSB_256 +: PW];       // [R6]
            byte_dec = {1'b0, hdr_nxt[7:0]};                              // [R6] [R16]
        end
    end

    assign hdr_end = (op_r == flash_seq_pkg::OP_PAGE_READ)
                   ? flash_seq_pkg::PAGE_READ_END                        // [R13]
                   : flash_seq_pkg::BUF_FAST_END;                        // [R15]

    // Command phase sequencing
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OPCODE:
            begin
                if (sy.sck_rise && hcnt_r == flash_seq_pkg::OPCODE_END)   // [R1]
                begin
                    state_nxt = op_known ? ST_ADDR : ST_SKIP;
                end
            end
            ST_ADDR:
            begin
                if (sy.sck_rise && hcnt_r == flash_seq_pkg::ADDR_END)
                begin
                    if (op_r == flash_seq_pkg::OP_BUF_WRITE)
                    begin
                        state_nxt = ST_WRITE;                             // [R18]
                    end
                    else if (op_r == flash_seq_pkg::OP_PAGE_READ
                          || op_r == flash_seq_pkg::OP_BUF_READ_FAST)
                    begin
                        state_nxt = ST_DUMMY;                             // [R13] [R15]
                    end
                    else
                    begin
                        state_nxt = ST_READ;                              // [R3] [R4] [R15]
                    end
                end
            end
            ST_DUMMY:
            begin
                if (sy.sck_rise && hcnt_r == hdr_end)
                begin
                    state_nxt = ST_READ;
                end
            end
            ST_READ:  state_nxt = ST_READ;
            ST_WRITE: state_nxt = ST_WRITE;
            ST_SKIP:  state_nxt = ST_SKIP;
        endcase
    end

    // Select high returns to opcode phase whatever the command was doing
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_OPCODE;
        end
        else if (!sy.cs_low)
        begin
            state_r <= ST_OPCODE;                                         // [R10] [R20]
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hcnt_r <= 7'h00;
            hdr_r  <= 32'h0;
            op_r   <= 8'h00;
        end
        else if (!sy.cs_low)
        begin
            hcnt_r <= 7'h00;
        end
        else if (sy.sck_rise && (state_r == ST_OPCODE || state_r == ST_ADDR
                              || state_r == ST_DUMMY))
        begin
            hcnt_r <= hcnt_r + 7'h01;
            hdr_r  <= hdr_nxt;
            if (state_r == ST_OPCODE && hcnt_r == flash_seq_pkg::OPCODE_END)
            begin
                op_r <= op_in;                                            // [R1]
            end
        end
    end

    // Operation class and wrap point for the current command
    assign is_buf_op  = (op_r == flash_seq_pkg::OP_BUF_READ_FAST)
                     || (op_r == flash_seq_pkg::OP_BUF_READ_SLOW)
                     || (op_r == flash_seq_pkg::OP_BUF_WRITE);
    assign is_page_op = (op_r == flash_seq_pkg::OP_PAGE_READ);
    assign last_byte  = sy.page_264 ? flash_seq_pkg::LAST_BYTE_264
                                    : flash_seq_pkg::LAST_BYTE_256;      // [R21]
    // Greater-or-equal keeps an out-of-range start offset from running off the end
    assign at_last    = (byte_r >= last_byte);

    // Pointer advances when a read byte is launched or a write byte lands
    assign advance = (state_r == ST_READ && sy.sck_fall && obit_r == 3'h0)
                  || buf_wr_en;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            page_r <= '0;
            byte_r <= '0;
        end
        else if (sy.sck_rise && state_r == ST_ADDR
              && hcnt_r == flash_seq_pkg::ADDR_END)
        begin
            page_r <= page_dec;                                           // [R12]
            byte_r <= byte_dec;                                           // [R16] [R18]
        end
        else if (advance)
        begin
            if (at_last)
            begin
                byte_r <= '0;                                             // [R17] [R19] [R14]
                if (!is_buf_op && !is_page_op)
                begin
                    // Ten-bit page counter rolls from the last page to page zero
                    page_r <= page_r + 10'h001;                           // [R7] [R8]
                end
            end
            else
            begin
                byte_r <= byte_r + 9'h001;
            end
        end
    end

    // Main array: preload port and registered read, never the buffer
    assign arr_idx = IW'({9'h000, page_r} * flash_seq_pkg::PAGE_STRIDE) + IW'(byte_r);
    assign ld_idx  = IW'({9'h000, arr_ld_page} * flash_seq_pkg::PAGE_STRIDE)
                   + IW'(arr_ld_byte);

    always_ff @(posedge clk)
    begin
        if (arr_ld_en)
        begin
            array_mem[ld_idx] <= arr_ld_data;
        end
    end

    always_ff @(posedge clk)
    begin
        arr_q_r <= array_mem[arr_idx];                                    // [R11]
    end

    assign src_byte = is_buf_op ? buf_q : arr_q_r;

    // Output shifter: new bit on each falling serial clock edge in read phase.
    // Prefetch has eight serial clocks to settle, so the next byte is never late.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            obit_r <= 3'h0;
            osh_r  <= 8'h00;
            so_r   <= 1'b0;
            oe_n_r <= 1'b1;
        end
        else if (!sy.cs_low)
        begin
            obit_r <= 3'h0;
            oe_n_r <= 1'b1;                                               // [R10]
        end
        else if (state_r == ST_READ && sy.sck_fall)
        begin
            oe_n_r <= 1'b0;
            obit_r <= obit_r + 3'h1;
            if (obit_r == 3'h0)
            begin
                so_r  <= src_byte[7];                                     // [R2] [R7]
                osh_r <= {src_byte[6:0], 1'b0};
            end
            else
            begin
                so_r  <= osh_r[7];                                        // [R2]
                osh_r <= {osh_r[6:0], 1'b0};
            end
        end
    end

    // Buffer write: assemble bytes on rising edges, partial byte dropped at select rise
    assign wbyte     = {wsh_r[6:0], sy.si_bit};                           // [R2]
    assign buf_wr_en = (state_r == ST_WRITE) && sy.cs_low && sy.sck_rise
                    && (wbit_r == flash_seq_pkg::BYTE_LAST_BIT);          // [R19] [R20]

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wbit_r <= 3'h0;
            wsh_r  <= 8'h00;
        end
        else if (!sy.cs_low)
        begin
            wbit_r <= 3'h0;
        end
        else if (state_r == ST_WRITE && sy.sck_rise)
        begin
            wbit_r <= wbit_r + 3'h1;
            wsh_r  <= wbyte;
        end
    end

    assign so_o    = so_r;
    assign so_oe_n = oe_n_r;
    // Host must keep select low to continue; busy mirrors the framed command
    assign busy    = sy.cs_low;                                           // [R9]

endmodule : flash_read_seq

// *** flash_read_seq_chk.sv ***
// Pin-level checks for the flash read sequencer, bound to its top module.
// Assumes sck runs several times slower than clk, as the pin sampler needs.
`timescale 1ns/1ps
module flash_read_seq_chk
#(
    parameter int PAGES     = 1024,
    parameter int PAGE_SIZE = 264
)
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Serial pins
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       si,
    input wire logic       so_o,
    input wire logic       so_oe_n,
    // Configuration and preload
    input wire logic       page_264,
    input wire logic       arr_ld_en,
    input wire logic [9:0] arr_ld_page,
    input wire logic [8:0] arr_ld_byte,
    input wire logic [7:0] arr_ld_data,
    // Status
    input wire logic       busy
);
    logic       sck_r;
    logic [3:0] fall_age_r;
    logic [6:0] rise_cnt_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clk or posedge rst)
        if (rst)
            sck_r <= 1'b0;
        else
            sck_r <= sck;

    // Raw pin view: the design's sampler lags this by a few cycles
    always_ff @(posedge clk or posedge rst)
        if (rst)
            fall_age_r <= 4'hf;
        else if (sck_r && !sck)
            fall_age_r <= 4'h0;
        else if (fall_age_r != 4'hf)
            fall_age_r <= fall_age_r + 4'h1;

    always_ff @(posedge clk or posedge rst)
        if (rst)
            rise_cnt_r <= 7'h00;
        else if (cs_n)
            rise_cnt_r <= 7'h00;
        else if (!sck_r && sck && rise_cnt_r != 7'h7f)
            rise_cnt_r <= rise_cnt_r + 7'h01;

    busy_follow_a: assert property ($fell(cs_n) |-> ##[1:4] busy)
        else $error("busy did not follow select fall");
    busy_drop_a: assert property ($rose(cs_n) |-> ##[1:4] !busy)
        else $error("busy did not drop after select rise");
    oe_release_a: assert property ($rose(cs_n) |-> ##[1:5] so_oe_n)
        else $error("output not released after select rise");
    oe_idle_a: assert property (cs_n [*6] |-> so_oe_n)
        else $error("output driven while deselected");
    oe_late_a: assert property ($fell(so_oe_n) |-> !cs_n && rise_cnt_r >= 7'h20)
        else $error("output driven before header complete");
    oe_on_fall_a: assert property ($fell(so_oe_n) |-> fall_age_r <= 4'h6)
        else $error("output enabled away from clock fall");
    oe_hold_a: assert property (!so_oe_n && !cs_n |=> !so_oe_n)
        else $error("output gap inside read frame");
    so_on_fall_a: assert property (!so_oe_n && !$past(so_oe_n) && $changed(so_o)
        |-> fall_age_r <= 4'h6)
        else $error("data changed away from clock fall");
endmodule : flash_read_seq_chk

bind flash_read_seq flash_read_seq_chk #(.PAGES(PAGES), .PAGE_SIZE(PAGE_SIZE)) u_chk (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o), .so_oe_n(so_oe_n),
    .page_264(page_264), .arr_ld_en(arr_ld_en), .arr_ld_page(arr_ld_page),
    .arr_ld_byte(arr_ld_byte), .arr_ld_data(arr_ld_data), .busy(busy));

// *** spi_host_model.sv ***
// Behavioural SPI host in mode 0: sck idles low and stands still between frames.
// Assumes the device shifts on sck fall; data is taken just before the next fall.
`timescale 1ns/1ps
module spi_host_model
#(
    parameter int HALF_NS = 24
)
(
    // Serial pins
    output logic       cs_n,
    output logic       sck,
    output logic       si,
    input  wire logic  so_o,
    input  wire logic  so_oe_n,
    // Received bytes
    output logic       rx_valid,
    output logic [7:0] rx_byte
);
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end

    task automatic start();
        cs_n = 1'b0;
        #HALF_NS;
    endtask : start

    // Select stays low across every byte of a frame
    task automatic xfer(input logic [7:0] tx, input bit rx);
        for (int i = 7; i >= 0; i--)
        begin
            si = tx[i];
            #HALF_NS sck = 1'b1;
            #HALF_NS;
            if (rx)
                rx_byte = {rx_byte[6:0], so_oe_n ? 1'bx : so_o};
            sck = 1'b0;
        end
        if (rx)
        begin
            rx_valid = 1'b1;
            #0.5 rx_valid = 1'b0;
        end
    endtask : xfer

    // A released input must not keep looking valid
    task automatic stop();
        #HALF_NS cs_n = 1'b1;
        si = ~si;
    endtask : stop
endmodule : spi_host_model

// *** flash_read_seq_tb_top.sv ***
// Self-checking bench for the flash read sequencer with a behavioural SPI host.
// Assumes only the preloaded pages are read; frames are spaced by idle cycles.
`timescale 1ns/1ps
module flash_read_seq_tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       page_264 = 1'b1;
    logic       arr_ld_en = 1'b0;
    logic [9:0] arr_ld_page = 10'h000;
    logic [8:0] arr_ld_byte = 9'h000;
    logic [7:0] arr_ld_data = 8'h00;
    wire logic  cs_n, sck, si, so_o, so_oe_n, busy, rx_valid;
    wire logic [7:0] rx_byte;
    int         seed = 1287;
    int         fail_count = 0;
    int         num_checks = 0;
    logic [7:0] arr [int];
    logic [7:0] bfr [0:263];
    logic [7:0] exp_q [$];

    always #2.5 clk = ~clk;

    flash_read_seq u_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o),
        .so_oe_n(so_oe_n), .page_264(page_264), .arr_ld_en(arr_ld_en),
        .arr_ld_page(arr_ld_page), .arr_ld_byte(arr_ld_byte), .arr_ld_data(arr_ld_data),
        .busy(busy));
    spi_host_model u_host (.cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o), .so_oe_n(so_oe_n),
        .rx_valid(rx_valid), .rx_byte(rx_byte));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic load_page(input int pg);
        for (int b = 0; b < 264; b++)
        begin
            @(negedge clk);
            arr_ld_en = 1'b1;
            arr_ld_page = 10'(pg);
            arr_ld_byte = 9'(b);
            arr_ld_data = 8'($random(seed));
            arr[pg * 264 + b] = arr_ld_data;
        end
        @(negedge clk);
        arr_ld_en = 1'b0;
    endtask : load_page

    // One frame; read bytes are noted for the monitor, written bytes go to the model
    task automatic cmd(input logic [7:0] op, input logic [23:0] adr, input int n);
        int         sz, pg, by, dum, kind;
        logic [7:0] d;
        sz = page_264 ? 264 : 256;
        pg = page_264 ? adr[18:9] : adr[17:8];
        by = page_264 ? adr[8:0] : adr[7:0];
        dum = (op == flash_seq_pkg::OP_PAGE_READ) ? 4 :
              (op == flash_seq_pkg::OP_BUF_READ_FAST) ? 1 : 0;
        kind = (op == flash_seq_pkg::OP_BUF_WRITE) ? 3 :
               (op inside {flash_seq_pkg::OP_BUF_READ_FAST, flash_seq_pkg::OP_BUF_READ_SLOW}) ? 2 :
               (op == flash_seq_pkg::OP_PAGE_READ) ? 1 :
               (op == flash_seq_pkg::OP_READ_LOW_FREQ) ? 0 :
               (op == flash_seq_pkg::OP_READ_LOW_POWER) ? 0 : 4;
        @(negedge clk);
        u_host.start();
        u_host.xfer(op, 1'b0);
        for (int i = 2; i >= 0; i--)
            u_host.xfer(adr[i * 8 +: 8], 1'b0);
        repeat (dum) u_host.xfer(8'($random(seed)), 1'b0);
        chk(busy, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($random(seed));
            if (kind == 3)
                bfr[by] = d;
            else if (kind != 4)
                exp_q.push_back(kind == 2 ? bfr[by] : arr[pg * 264 + by]);
            u_host.xfer(d, kind < 3);
            if (kind == 4)
                chk(so_oe_n, 1'b1);
            by++;
            // A start offset past the page end wraps at the next byte
            if (by >= sz)
            begin
                by = 0;
                if (kind == 0)
                    pg = (pg + 1) % 1024;
            end
        end
        u_host.stop();
        repeat (6) @(negedge clk);
        chk(so_oe_n, 1'b1);
        chk(busy, 1'b0);
        $display("frame %h done", op);
    endtask : cmd

    // A byte that nobody expected is a mismatch in itself
    always @(posedge rx_valid)
        if (exp_q.size() == 0)
            chk(32'h1, 32'h0);
        else
            chk(rx_byte, exp_q.pop_front());

    initial
    begin
        #300000;
        fail_count++;
        conclude();
    end

    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        load_page(0);
        load_page(1);
        load_page(5);
        load_page(1023);
        cmd(flash_seq_pkg::OP_BUF_WRITE, {15'h0, 9'h106}, 4);
        cmd(flash_seq_pkg::OP_READ_LOW_FREQ, {5'h0, 10'h000, 9'h106}, 4);
        cmd(flash_seq_pkg::OP_READ_LOW_POWER, {5'h0, 10'h3ff, 9'h106}, 4);
        cmd(flash_seq_pkg::OP_PAGE_READ, {5'h0, 10'h005, 9'h106}, 4);
        cmd(flash_seq_pkg::OP_BUF_READ_FAST, {15'h0, 9'h106}, 4);
        cmd(flash_seq_pkg::OP_BUF_READ_SLOW, 24'h000000, 2);
        cmd(flash_seq_pkg::OP_READ_LOW_FREQ, {5'h0, 10'h000, 1'b1, 8'($random(seed))}, 3);
        cmd(8'h5a, 24'h000000, 2);
        @(negedge clk);
        page_264 = 1'b0;
        repeat (4) @(negedge clk);
        cmd(flash_seq_pkg::OP_BUF_WRITE, 24'h0000ff, 2);
        cmd(flash_seq_pkg::OP_BUF_READ_SLOW, 24'h0000ff, 3);
        cmd(flash_seq_pkg::OP_READ_LOW_FREQ, {6'h0, 10'h000, 8'hfe}, 4);
        cmd(flash_seq_pkg::OP_READ_LOW_POWER, {6'h0, 10'h3ff, 8'hfe}, 4);
        cmd(flash_seq_pkg::OP_PAGE_READ, {6'h0, 10'h005, 8'hff}, 2);
        chk(exp_q.size(), 0);
        conclude();
    end
endmodule : flash_read_seq_tb_top
